// >>> rtl/rt_status_defines.vh
// Constants for the runtime status register slice
`ifndef RT_STATUS_DEFINES_VH
`define RT_STATUS_DEFINES_VH

// Register offsets
`define OFS_UPTIME_BYTE1 8'h71
`define OFS_UPTIME_BYTE2 8'h72
`define OFS_UPTIME_BYTE3 8'h73
`define OFS_UPTIME_BYTE4 8'h74
`define OFS_SMBUS_ADDR 8'h76
`define OFS_ARBITRATION 8'h77
`define OFS_PM_STATUS_ONE 8'h78
`define OFS_PM_STATUS_TWO 8'h79

// Slave address register fields and standby reset value (low two bits from straps)
`define SADDR_EN_BIT 7
`define SADDR_RESET_HI 6'h2b

// Arbitration register fields and reset value
`define ARB_REQ_BIT 0
`define ARB_GNT_BIT 1
`define ARB_RESET 8'h02

// Power management status two fields and reset value
`define PM2_BTN_BIT 0
`define PM2_OVR_BIT 3
`define PM2_TOP_BIT 7
`define PM2_RESET 8'h00

// Button override hold time
`define CLK_KHZ 50000
`define OVR_HOLD_MS 4000
`define OVR_HOLD_CYCLES (`OVR_HOLD_MS * `CLK_KHZ)

`endif

// >>> rtl/button_hold_timer.v
// Button hold timer: one pulse once the button is held longer than the limit
`timescale 1ns/1ps
`default_nettype none
module button_hold_timer #(
	parameter [31:0] HOLD_CYCLES = 32'd200000000
) (
	input wire clk,
	input wire rstn,
	input wire held,
	output reg expired
);
	reg [31:0] count_r;
	reg fired_r;

	// Fires once per press; release rearms it
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			count_r <= 32'h0;
			fired_r <= 1'b0;
			expired <= 1'b0;
		end
		else if (!held)
		begin
			count_r <= 32'h0;
			fired_r <= 1'b0;
			expired <= 1'b0;
		end
		else
		begin
			if (count_r <= HOLD_CYCLES)
				count_r <= count_r + 32'h1;
			expired <= (count_r == HOLD_CYCLES) && !fired_r;
			if (count_r == HOLD_CYCLES)
				fired_r <= 1'b1;
		end
	end
endmodule // button_hold_timer
`default_nettype wire

// >>> rtl/runtime_status_register_slice.v
// Runtime status register slice: uptime bytes, serial slave address, arbitration, power button
//
// Notes on behaviour
// - Offset 0x71 reads uptime bits 7..0
// - Offset 0x72 reads uptime bits 15..8
// - Offset 0x73 reads uptime bits 23..16
// - Offset 0x74 reads uptime bits 31..24
// - Slave address low bits sampled from straps
// - Standby reset loads 101011 plus strap bits
// - Enable bit gates serial controller entirely
// - Grant bit driven only by arbitration logic
// - Arbitration resets 0x02; soft reset keeps grant
// - Status byte one always reads zero
// - Button press sets button flag
// - Wake event while flag and enable set
// - Press in soft-off wakes supply regardless
// - Flag cleared by write-one, hold expiry or battery reset
// - Status two resets zero; bit 7 on standby
// - Held over four seconds forces override, soft-off
`include "rt_status_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module runtime_status_register_slice #(
	parameter [31:0] OVR_HOLD_CYCLES = `OVR_HOLD_CYCLES
) (
	input wire clk,
	input wire rstn,
	input wire standby_por,
	input wire main_por,
	input wire host_bus_reset,
	input wire soft_reset,
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire [31:0] standby_uptime,
	input wire addr_strap_low,
	input wire addr_strap_high,
	output reg [6:0] smbus_slave_addr,
	output reg second_serial_mgmt_controller_en,
	output reg host_bus_request,
	input wire grant_set,
	input wire grant_clear,
	input wire button_input_n,
	input wire button_event_enable,
	input wire pm_top_event,
	output reg wake_event_out_n,
	output reg supply_on_out_n,
	output reg supply_on_oe
);
	reg [7:0] saddr_r;
	reg [7:0] saddr_nxt;
	reg req_r;
	reg req_nxt;
	reg gnt_r;
	reg gnt_nxt;
	reg btn_flag_r;
	reg btn_flag_nxt;
	reg ovr_flag_r;
	reg ovr_flag_nxt;
	reg top_flag_r;
	reg top_flag_nxt;
	reg supply_on_r;
	reg supply_on_nxt;
	reg button_prev_r;
	reg [7:0] rdata_nxt;
	wire press_edge;
	wire hold_expired;
	wire wr_saddr;
	wire wr_arb;
	wire wr_pm2;
	wire hard_arb_reset;

	// Reset image of the arbitration register; only its two live bits are kept as flops
	localparam [7:0] ARB_RESET_VAL = `ARB_RESET;

	assign press_edge = button_prev_r && !button_input_n;
	assign wr_saddr = reg_wr && (reg_addr == `OFS_SMBUS_ADDR);
	assign wr_arb = reg_wr && (reg_addr == `OFS_ARBITRATION);
	assign wr_pm2 = reg_wr && (reg_addr == `OFS_PM_STATUS_TWO);
	assign hard_arb_reset = standby_por || main_por || host_bus_reset;

	button_hold_timer #(
		.HOLD_CYCLES(OVR_HOLD_CYCLES)
	) u_hold (
		.clk(clk),
		.rstn(rstn),
		.held(!button_input_n),
		.expired(hold_expired)
	);

	// Slave address and enable
	always @*
	begin
		saddr_nxt = saddr_r;
		if (standby_por)
		begin
			// Straps are caught on the clock, never by the async reset
			saddr_nxt = {`SADDR_RESET_HI, addr_strap_high, addr_strap_low};
		end
		else if (wr_saddr)
		begin
			saddr_nxt = reg_wdata;
		end
	end

	// Arbitration request and grant
	always @*
	begin
		req_nxt = req_r;
		gnt_nxt = gnt_r;
		if (hard_arb_reset)
		begin
			req_nxt = ARB_RESET_VAL[`ARB_REQ_BIT];
			gnt_nxt = ARB_RESET_VAL[`ARB_GNT_BIT];
		end
		else if (soft_reset)
		begin
			req_nxt = 1'b0;
		end
		else
		begin
			if (wr_arb)
				req_nxt = reg_wdata[`ARB_REQ_BIT];
			// Host writes never reach the grant
			if (grant_set)
				gnt_nxt = 1'b1;
			else if (grant_clear)
				gnt_nxt = 1'b0;
		end
	end

	// Power management status two and supply state
	always @*
	begin
		btn_flag_nxt = btn_flag_r;
		ovr_flag_nxt = ovr_flag_r;
		top_flag_nxt = top_flag_r;
		supply_on_nxt = supply_on_r;
		if (wr_pm2)
		begin
			// Write one clears, write zero keeps
			if (reg_wdata[`PM2_BTN_BIT])
				btn_flag_nxt = 1'b0;
			if (reg_wdata[`PM2_OVR_BIT])
				ovr_flag_nxt = 1'b0;
			if (reg_wdata[`PM2_TOP_BIT])
				top_flag_nxt = 1'b0;
		end
		// Hardware sets after the clear so a same-cycle event survives
		if (pm_top_event)
			top_flag_nxt = 1'b1;
		if (press_edge)
		begin
			btn_flag_nxt = 1'b1;
			if (!supply_on_r)
				supply_on_nxt = 1'b1;
		end
		if (hold_expired)
		begin
			btn_flag_nxt = 1'b0;
			ovr_flag_nxt = 1'b1;
			supply_on_nxt = 1'b0;
		end
		if (standby_por)
			top_flag_nxt = 1'b0;
	end

	// Read mux
	always @*
	begin
		case (reg_addr)
			`OFS_UPTIME_BYTE1:
			begin
				rdata_nxt = standby_uptime[7:0];
			end
			`OFS_UPTIME_BYTE2:
			begin
				rdata_nxt = standby_uptime[15:8];
			end
			`OFS_UPTIME_BYTE3:
			begin
				rdata_nxt = standby_uptime[23:16];
			end
			`OFS_UPTIME_BYTE4:
			begin
				rdata_nxt = standby_uptime[31:24];
			end
			`OFS_SMBUS_ADDR:
			begin
				rdata_nxt = saddr_r;
			end
			`OFS_ARBITRATION:
			begin
				rdata_nxt = {6'h00, gnt_r, req_r};
			end
			`OFS_PM_STATUS_ONE:
			begin
				rdata_nxt = 8'h00;
			end
			`OFS_PM_STATUS_TWO:
			begin
				rdata_nxt = {top_flag_r, 3'h0, ovr_flag_r, 2'h0, btn_flag_r};
			end
			default:
			begin
				rdata_nxt = 8'h00;
			end
		endcase
	end

	// Battery reset is the async reset; the uptime counter is cleared by its owner on it
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			saddr_r <= 8'h00;
			req_r <= 1'b0;
			gnt_r <= 1'b1;
			btn_flag_r <= 1'b0;
			ovr_flag_r <= 1'b0;
			top_flag_r <= 1'b0;
			supply_on_r <= 1'b0;
			button_prev_r <= 1'b1;
		end
		else
		begin
			saddr_r <= saddr_nxt;
			req_r <= req_nxt;
			gnt_r <= gnt_nxt;
			btn_flag_r <= btn_flag_nxt;
			ovr_flag_r <= ovr_flag_nxt;
			top_flag_r <= top_flag_nxt;
			supply_on_r <= supply_on_nxt;
			button_prev_r <= button_input_n;
		end
	end

	// Read data holds until the next read strobe
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rdata_nxt;
	end

	// Registered pin outputs, one cycle behind the state
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			smbus_slave_addr <= 7'h00;
		else
			smbus_slave_addr <= saddr_r[6:0];
	end

	// Controller must ignore the bus and leave both lines alone when clear
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			second_serial_mgmt_controller_en <= 1'b0;
		else
			second_serial_mgmt_controller_en <= saddr_r[`SADDR_EN_BIT];
	end

	// Request pin mirrors arbitration bit 0
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			host_bus_request <= 1'b0;
		else
			host_bus_request <= req_r;
	end

	// Wake event follows flag and enable, not a pulse
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			wake_event_out_n <= 1'b1;
		else
			wake_event_out_n <= !(btn_flag_r && button_event_enable);
	end

	// Soft-off floats the supply pin rather than driving it high
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			supply_on_out_n <= 1'b1;
		else
			supply_on_out_n <= 1'b0;
	end

	// Output enable carries the whole on/off state
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			supply_on_oe <= 1'b0;
		else
			supply_on_oe <= supply_on_r;
	end
endmodule // runtime_status_register_slice
`default_nettype wire

// >>> bench/rsrs_asserts.sv
// Checker for the runtime status register slice ports
`timescale 1ns/1ps
`default_nettype none
module rsrs_asserts (
	input wire logic clk,
	input wire logic rstn,
	input wire logic main_por,
	input wire logic host_bus_reset,
	input wire logic soft_reset,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [31:0] standby_uptime,
	input wire logic host_bus_request,
	input wire logic button_input_n,
	input wire logic button_event_enable,
	input wire logic wake_event_out_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence press_en;
		$fell(button_input_n) && button_event_enable && !reg_wr;
	endsequence
	sequence keep_en;
		button_event_enable && !reg_wr;
	endsequence
	a_uptime_bytes: assert property (
		reg_rd && reg_addr inside {[8'h71:8'h74]} |=>
		reg_rdata == 8'($past(standby_uptime >> {reg_addr[2:0] - 3'd1, 3'b000})))
		else $error("uptime byte mismatch");
	a_status_one: assert property (reg_rd && reg_addr == 8'h78 |=> reg_rdata == 8'h00)
		else $error("status one not zero");
	a_arb_reserved: assert property (reg_rd && reg_addr == 8'h77 |=> reg_rdata[7:2] == 6'h00)
		else $error("arbitration reserved bits set");
	a_wake_press: assert property (press_en ##1 keep_en [*2] |=> !wake_event_out_n)
		else $error("no wake event after press");
	a_wake_off: assert property (!button_event_enable |=> wake_event_out_n)
		else $error("wake event while disabled");
	a_soft_req: assert property (soft_reset ##1 !reg_wr |=> !host_bus_request)
		else $error("request kept over soft reset");
	a_host_req: assert property (host_bus_reset ##1 !reg_wr |=> !host_bus_request)
		else $error("request kept over host reset");
	a_main_req: assert property (main_por ##1 !reg_wr |=> !host_bus_request)
		else $error("request kept over main reset");
endmodule // rsrs_asserts
bind runtime_status_register_slice rsrs_asserts u_rsrs_asserts (.*);
`default_nettype wire

// >>> bench/host_model.sv
// Host controller model for the register port
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic clk,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] reg_addr = 8'h00,
	output logic reg_wr = 1'b0,
	output logic [7:0] reg_wdata = 8'h00,
	output logic reg_rd = 1'b0
);
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_wdata = ~v; // Stale data must not look valid
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		@(negedge clk);
		v = reg_rdata;
	endtask
endmodule // host_model
`default_nettype wire

// >>> bench/runtime_status_register_slice_tb_top.sv
// Testbench for the runtime status register slice
`timescale 1ns/1ps
`default_nettype none
module runtime_status_register_slice_tb_top;
	logic clk = 0, rstn = 0, standby_por = 0, main_por = 0, host_bus_reset = 0, soft_reset = 0;
	logic addr_strap_low = 0, addr_strap_high = 1, grant_set = 0, grant_clear = 0, pm_top_event = 0;
	logic button_input_n = 1, button_event_enable = 0, reg_wr, reg_rd, host_bus_request;
	logic second_serial_mgmt_controller_en, wake_event_out_n, supply_on_out_n, supply_on_oe;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic [6:0] smbus_slave_addr;
	logic [31:0] standby_uptime = 32'h89abcdef;
	int error_cnt = 0, checks = 0;
	// Write flag, offset, data, expected read
	logic [24:0] rows [10] = '{25'h0_71_00_ef, 25'h0_72_00_cd, 25'h0_73_00_ab, 25'h0_74_00_89,
		25'h1_72_ff_cd, 25'h1_78_ff_00, 25'h1_77_fc_02, 25'h0_76_00_ae, 25'h1_76_12_12, 25'h1_77_01_03};
	runtime_status_register_slice #(.OVR_HOLD_CYCLES(32'd40)) u_runtime_status_register_slice (.*);
	host_model u_host_model (.*);
	always #10 clk = ~clk;
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask
	task automatic conclude();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		u_host_model.rd(8'h79, d);
		chk(d, 8'h00);
		pulse(standby_por);
		foreach (rows[i])
		begin
			if (rows[i][24])
				u_host_model.wr(rows[i][23:16], rows[i][15:8]);
			u_host_model.rd(rows[i][23:16], d);
			chk(d, rows[i][7:0]);
		end
		chk(second_serial_mgmt_controller_en, 8'h00);
		chk(smbus_slave_addr, 8'h12);
		pulse(grant_clear);
		u_host_model.rd(8'h77, d);
		chk(d, 8'h01);
		pulse(soft_reset);
		u_host_model.rd(8'h77, d);
		chk(d, 8'h00);
		pulse(grant_set);
		u_host_model.wr(8'h77, 8'h01);
		@(negedge clk);
		chk(host_bus_request, 8'h01);
		pulse(host_bus_reset);
		u_host_model.rd(8'h77, d);
		chk(d, 8'h02);
		u_host_model.wr(8'h77, 8'h01);
		pulse(main_por);
		button_input_n = 1'b0;
		repeat (3) @(negedge clk);
		chk(supply_on_oe, 8'h01);
		chk(supply_on_out_n, 8'h00);
		button_event_enable = 1'b1;
		repeat (2) @(negedge clk);
		chk(wake_event_out_n, 8'h00);
		u_host_model.wr(8'h79, 8'h00);
		u_host_model.rd(8'h79, d);
		chk(d, 8'h01);
		repeat (100) if (supply_on_oe !== 1'b0) @(negedge clk);
		chk(supply_on_oe, 8'h00);
		if (supply_on_oe !== 1'b0) conclude();
		u_host_model.rd(8'h79, d);
		chk(d, 8'h08);
		button_input_n = 1'b1;
		repeat (2) @(negedge clk);
		button_input_n = 1'b0;
		repeat (3) @(negedge clk);
		chk({supply_on_oe, wake_event_out_n}, 8'h02);
		pulse(pm_top_event);
		u_host_model.rd(8'h79, d);
		chk(d, 8'h89);
		pulse(standby_por);
		u_host_model.rd(8'h79, d);
		chk(d, 8'h09);
		chk(second_serial_mgmt_controller_en, 8'h01);
		chk(smbus_slave_addr, 8'h2e);
		u_host_model.wr(8'h79, 8'hff);
		u_host_model.rd(8'h79, d);
		chk(d, 8'h00);
		conclude();
	end
endmodule // runtime_status_register_slice_tb_top
`default_nettype wire
